// >>> design/dirqc_regs.svh
// Register offsets, field positions, reset values and masks of the dual interrupt controller
`ifndef DIRQC_REGS_SVH
`define DIRQC_REGS_SVH

// ---------------------------------------------------------------
// Byte offsets on the register bus
// ---------------------------------------------------------------
`define DIRQC_OFS_POL 16'h3000
`define DIRQC_OFS_CLR 16'h3004
`define DIRQC_OFS_SEL_A 16'h3008
`define DIRQC_OFS_SEL_B 16'h300C
`define DIRQC_OFS_FLAG_A 16'h3010
`define DIRQC_OFS_FLAG_B 16'h3014
`define DIRQC_OFS_PINSEL 16'h3018
`define DIRQC_OFS_FIFOTHR 16'h301C
`define DIRQC_OFS_EXTCFG 16'h3020
`define DIRQC_OFS_EXTSTA 16'h3024
`define DIRQC_OFS_CUSTOM 16'h209C

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define DIRQC_RST_POL 1'h0
`define DIRQC_RST_SEL 32'h00002000
`define DIRQC_RST_PINSEL 6'h00
`define DIRQC_RST_FIFOTHR 11'h000
`define DIRQC_RST_EXTCFG 32'h00000000
`define DIRQC_RST_CUSTOM 4'h0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DIRQC_POL_BIT 0
`define DIRQC_PINSEL_A_LSB 0
`define DIRQC_PINSEL_A_EN 2
`define DIRQC_PINSEL_B_SEL 4
`define DIRQC_PINSEL_B_EN 5
`define DIRQC_CUSTOM_LSB 9
`define DIRQC_FIFO_THR_BIT 25
`define DIRQC_BREAK_BIT 31

// Flag bits that own a source; every other bit reads zero
`define DIRQC_FLAG_MASK 32'hAF83BFFF
// Source bits generated inside this block rather than from src_evt_i
`define DIRQC_LOCAL_MASK 32'h82001E00

`endif

// >>> design/dirqc_pkg.sv
// Types shared by the dual interrupt controller modules
package dirqc_pkg;

  // Pin choice for the first group output
  typedef enum logic [1:0] {
    DIRQC_A_PIN0,
    DIRQC_A_PIN3,
    DIRQC_A_PIN6,
    DIRQC_A_NONE
  } dirqc_pina_t;

  // Per-detector mode bits: rise, fall, high level, low level
  typedef struct packed {
    logic low_lvl;
    logic high_lvl;
    logic fall;
    logic rise;
  } dirqc_extcfg_t;

endpackage : dirqc_pkg

// >>> design/dirqc_ext_det.sv
// Eight external interrupt detectors with edge and level modes
`timescale 1ns/100ps
`default_nettype none

module dirqc_ext_det (
  input wire logic clk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable
  input wire logic [7:0] ext_pin_i, // External interrupt inputs
  input wire logic [31:0] cfg_i, // Four mode bits per detector
  output logic [7:0] det_o // Detector interrupt lines
);

  logic [7:0] prev_r;
  logic [7:0] prev_nxt;
  dirqc_pkg::dirqc_extcfg_t cfg [8];

  // ---------------------------------------------------------------
  // Previous pin level for edge detection
  // ---------------------------------------------------------------
  assign prev_nxt = ext_pin_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_r <= ext_pin_i; // Track pin in reset, no false edge after
    end else if (ce_i) begin
      prev_r <= prev_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Edge pulses and level hold per detector
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_det
    assign cfg[i] = cfg_i[4*i +: 4];
    assign det_o[i] = (cfg[i].rise & ext_pin_i[i] & ~prev_r[i]) | // [R12] [R13]
                      (cfg[i].fall & ~ext_pin_i[i] & prev_r[i]) | // [R13]
                      (cfg[i].high_lvl & ext_pin_i[i]) | // [R14]
                      (cfg[i].low_lvl & ~ext_pin_i[i]); // [R14]
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  wire [7:0] rise_en = {cfg[7].rise, cfg[6].rise, cfg[5].rise, cfg[4].rise,
                        cfg[3].rise, cfg[2].rise, cfg[1].rise, cfg[0].rise};
  wire [7:0] high_en = {cfg[7].high_lvl, cfg[6].high_lvl, cfg[5].high_lvl, cfg[4].high_lvl,
                        cfg[3].high_lvl, cfg[2].high_lvl, cfg[1].high_lvl, cfg[0].high_lvl};

  a_edge_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R13]
    (ce_i && ((rise_en & ext_pin_i & ~prev_r) != 8'h00)) |-> ((det_o & rise_en & ext_pin_i & ~prev_r) != 8'h00))
    else $error("rising edge gave no detector pulse");
  a_level_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R14]
    ((high_en & ext_pin_i & ~det_o) == 8'h00))
    else $error("high level not held on detector line");

endmodule : dirqc_ext_det

`default_nettype wire

// >>> design/dirqc_top.sv
// Dual interrupt controller with Avalon-MM register slave and external detectors
//
// Contract
// (R1) Two groups: own enable and flags, shared polarity/clear
// (R2) Enabled source event sets group flag bit
// (R3) Host routes pin before enabling sources
// (R4) Group A output goes to pin 0, 3, 6
// (R5) Group B output goes to pin 4, 7
// (R6) Polarity register picks rising or falling edge
// (R7) Triggered enabled interrupt toggles the selected pin
// (R8) Writing clear bit clears that flag
// (R9) Four custom sources at enable bits 12:9
// (R10) Custom events raised only by sequencer writes
// (R11) Bus writes to custom register are ignored
// (R12) Eight external detectors, any mode combination
// (R13) Edge modes give a single pulse
// (R14) Level modes hold line while level held
// (R15) External event wakes device from hibernate
// (R16) Flags 0-3: converter, transform, filter, temperature
// (R17) Flags 4-8: min, max, delta, mean, variance
// (R18) Flags 13, 15, 16, 17: boot, sequence, timeouts
// (R19) Flags 23-27: FIFO events, threshold from setting
// (R20) Flag 29 reports measurement outlier
// (R21) Flag 31: B request during A, B ignored
// (R22) Polarity bit 0: 0 falling, 1 rising
// (R23) Flags sticky until cleared; unassigned bits zero
// (R24) Group output is OR of enabled flags
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

`include "dirqc_regs.svh"

module dirqc_top (
  input wire logic clk_i, // System clock, 125 MHz
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes all state when low
  input wire logic [15:0] avs_address_i, // Avalon byte address
  input wire logic avs_read_i, // Avalon read request
  input wire logic avs_write_i, // Avalon write request
  input wire logic [31:0] avs_writedata_i, // Avalon write data
  input wire logic [3:0] avs_byteenable_i, // Avalon byte enables
  output logic [31:0] avs_readdata_o, // Avalon read data
  output logic avs_waitrequest_o, // Avalon wait request
  input wire logic [31:0] src_evt_i, // Source event pulses by flag bit
  input wire logic [10:0] fifo_level_i, // Data FIFO fill level
  input wire logic seq_a_busy_i, // First-priority sequence running
  input wire logic seq_b_req_i, // Second-priority sequence request
  output logic seq_b_accept_o, // Second-priority request accepted
  input wire logic seq_wr_i, // Sequencer write to custom events
  input wire logic [3:0] seq_wdata_i, // Sequencer custom event bits
  input wire logic [7:0] ext_pin_i, // External interrupt inputs
  input wire logic hibernate_i, // Device is in hibernate
  output logic [7:0] ext_irq_o, // External detector lines
  output logic wake_o, // Wake request from hibernate
  output logic [7:0] port_pin_n_o, // Interrupt level on port pins
  output logic [7:0] port_pin_own_o // Pins owned by interrupt outputs
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic output_polarity_reg_r;
  logic output_polarity_reg_nxt;
  logic [31:0] source_enable_reg_a_r;
  logic [31:0] source_enable_reg_a_nxt;
  logic [31:0] source_enable_reg_b_r;
  logic [31:0] source_enable_reg_b_nxt;
  logic [31:0] source_flag_reg_a_r;
  logic [31:0] source_flag_reg_a_nxt;
  logic [31:0] source_flag_reg_b_r;
  logic [31:0] source_flag_reg_b_nxt;
  logic [5:0] pinsel_r;
  logic [5:0] pinsel_nxt;
  logic [10:0] fifo_threshold_setting_r;
  logic [10:0] fifo_threshold_setting_nxt;
  logic [10:0] fifo_level_r;
  logic [31:0] extcfg_r;
  logic [31:0] extcfg_nxt;
  logic [7:0] extsta_r;
  logic [7:0] extsta_nxt;
  logic [3:0] custom_event_reg_r;
  logic [3:0] custom_event_reg_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [7:0] pin_r;
  logic [7:0] own_r;
  logic [7:0] ext_irq_r;
  logic wake_r;
  logic accept_r;
  logic [7:0] ext_det;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] dirqc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction : dirqc_merge

  // Sticky flag update: an event in the clearing cycle wins
  function automatic logic [31:0] dirqc_flag_nxt(input logic [31:0] flg, input logic [31:0] ev,
                                                 input logic [31:0] sel, input logic [31:0] clr);
    return ((flg & ~clr) | (ev & sel)) & `DIRQC_FLAG_MASK;
  endfunction : dirqc_flag_nxt

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire bus_req = avs_read_i | avs_write_i;
  wire wr_commit = ce_i & avs_write_i & ~wait_r;
  wire hit_pol = avs_address_i == `DIRQC_OFS_POL;
  wire hit_clr = avs_address_i == `DIRQC_OFS_CLR;
  wire hit_sel_a = avs_address_i == `DIRQC_OFS_SEL_A;
  wire hit_sel_b = avs_address_i == `DIRQC_OFS_SEL_B;
  wire hit_flag_a = avs_address_i == `DIRQC_OFS_FLAG_A;
  wire hit_flag_b = avs_address_i == `DIRQC_OFS_FLAG_B;
  wire hit_pinsel = avs_address_i == `DIRQC_OFS_PINSEL;
  wire hit_fifothr = avs_address_i == `DIRQC_OFS_FIFOTHR;
  wire hit_extcfg = avs_address_i == `DIRQC_OFS_EXTCFG;
  wire hit_extsta = avs_address_i == `DIRQC_OFS_EXTSTA;
  wire hit_custom = avs_address_i == `DIRQC_OFS_CUSTOM;
  wire [31:0] wmask_data = dirqc_merge(32'h00000000, avs_writedata_i, avs_byteenable_i);

  // Shared clear vector, one cycle at the committing edge
  wire [31:0] clr_vec = (wr_commit & hit_clr) ? wmask_data : 32'h00000000; // [R1] [R8]

  // Read mux; unmapped and write-only offsets read zero
  wire [31:0] rd_mux =
    hit_pol ? {31'h00000000, output_polarity_reg_r} :
    hit_sel_a ? source_enable_reg_a_r :
    hit_sel_b ? source_enable_reg_b_r :
    hit_flag_a ? source_flag_reg_a_r :
    hit_flag_b ? source_flag_reg_b_r :
    hit_pinsel ? {26'h0000000, pinsel_r} :
    hit_fifothr ? {21'h000000, fifo_threshold_setting_r} :
    hit_extcfg ? extcfg_r :
    hit_extsta ? {24'h000000, extsta_r} :
    hit_custom ? {28'h0000000, custom_event_reg_r} :
    32'h00000000;

  // Avalon handshake: one wait cycle, then commit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_r <= 1'h1;
      rdata_r <= 32'h00000000;
    end else if (ce_i) begin
      wait_r <= ~(bus_req & wait_r);
      rdata_r <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  assign output_polarity_reg_nxt = (wr_commit & hit_pol & avs_byteenable_i[0]) ?
                                   avs_writedata_i[`DIRQC_POL_BIT] : output_polarity_reg_r; // [R6] [R22]
  assign source_enable_reg_a_nxt = (wr_commit & hit_sel_a) ?
                                   dirqc_merge(source_enable_reg_a_r, avs_writedata_i, avs_byteenable_i) :
                                   source_enable_reg_a_r;
  assign source_enable_reg_b_nxt = (wr_commit & hit_sel_b) ?
                                   dirqc_merge(source_enable_reg_b_r, avs_writedata_i, avs_byteenable_i) :
                                   source_enable_reg_b_r;
  wire [31:0] pinsel_mrg = dirqc_merge({26'h0000000, pinsel_r}, avs_writedata_i, avs_byteenable_i);
  assign pinsel_nxt = (wr_commit & hit_pinsel) ? pinsel_mrg[5:0] : pinsel_r;
  wire [31:0] thr_mrg = dirqc_merge({21'h000000, fifo_threshold_setting_r}, avs_writedata_i, avs_byteenable_i);
  assign fifo_threshold_setting_nxt = (wr_commit & hit_fifothr) ? thr_mrg[10:0] : fifo_threshold_setting_r;
  assign extcfg_nxt = (wr_commit & hit_extcfg) ? dirqc_merge(extcfg_r, avs_writedata_i, avs_byteenable_i) :
                      extcfg_r;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      output_polarity_reg_r <= `DIRQC_RST_POL;
      source_enable_reg_a_r <= `DIRQC_RST_SEL;
      source_enable_reg_b_r <= `DIRQC_RST_SEL;
      pinsel_r <= `DIRQC_RST_PINSEL;
      fifo_threshold_setting_r <= `DIRQC_RST_FIFOTHR;
      extcfg_r <= `DIRQC_RST_EXTCFG;
    end else if (ce_i) begin
      output_polarity_reg_r <= output_polarity_reg_nxt;
      source_enable_reg_a_r <= source_enable_reg_a_nxt;
      source_enable_reg_b_r <= source_enable_reg_b_nxt;
      pinsel_r <= pinsel_nxt;
      fifo_threshold_setting_r <= fifo_threshold_setting_nxt;
      extcfg_r <= extcfg_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Event sources
  // ---------------------------------------------------------------
  // Custom events only from the sequencer port; bus writes reach them only as clears through bits 12:9
  wire [3:0] custom_evt = seq_wr_i ? seq_wdata_i : 4'h0; // [R10] [R11]
  assign custom_event_reg_nxt = custom_evt | (custom_event_reg_r & ~clr_vec[`DIRQC_CUSTOM_LSB +: 4]);
  // Threshold crossing of the FIFO fill level
  wire thr_evt = (fifo_level_i >= fifo_threshold_setting_r) & (fifo_level_r < fifo_threshold_setting_r); // [R19]
  // Second-priority request while first-priority runs is refused
  wire break_evt = seq_b_req_i & seq_a_busy_i; // [R21]

  // Flag bit map: outside sources at their own bits, local ones inserted
  wire [31:0] evt_all = (src_evt_i & ~`DIRQC_LOCAL_MASK) | // [R16] [R17] [R18] [R19] [R20]
                        ({27'h0000000, custom_evt, 1'h0} << (`DIRQC_CUSTOM_LSB - 1)) | // [R9]
                        ({31'h00000000, thr_evt} << `DIRQC_FIFO_THR_BIT) |
                        ({break_evt, 31'h00000000}); // [R21]

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      custom_event_reg_r <= `DIRQC_RST_CUSTOM;
      fifo_level_r <= 11'h000;
      accept_r <= 1'h0;
    end else if (ce_i) begin
      custom_event_reg_r <= custom_event_reg_nxt;
      fifo_level_r <= fifo_level_i;
      accept_r <= seq_b_req_i & ~seq_a_busy_i; // [R21]
    end
  end

  // ---------------------------------------------------------------
  // Group flags
  // ---------------------------------------------------------------
  assign source_flag_reg_a_nxt = dirqc_flag_nxt(source_flag_reg_a_r, evt_all, source_enable_reg_a_r,
                                                clr_vec); // [R1] [R2] [R8] [R23]
  assign source_flag_reg_b_nxt = dirqc_flag_nxt(source_flag_reg_b_r, evt_all, source_enable_reg_b_r,
                                                clr_vec); // [R1] [R2] [R8] [R23]

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      source_flag_reg_a_r <= 32'h00000000;
      source_flag_reg_b_r <= 32'h00000000;
    end else if (ce_i) begin
      source_flag_reg_a_r <= source_flag_reg_a_nxt;
      source_flag_reg_b_r <= source_flag_reg_b_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Group outputs and pin routing
  // ---------------------------------------------------------------
  wire irq_a = |(source_flag_reg_a_r & source_enable_reg_a_r); // [R24]
  wire irq_b = |(source_flag_reg_b_r & source_enable_reg_b_r); // [R24]
  // Idle level is the inverse of the active edge's end level
  wire lvl_a = output_polarity_reg_r ? irq_a : ~irq_a; // [R6] [R7] [R22]
  wire lvl_b = output_polarity_reg_r ? irq_b : ~irq_b; // [R6] [R7] [R22]
  wire [1:0] pina_code = pinsel_r[`DIRQC_PINSEL_A_LSB +: 2];
  wire a_en = pinsel_r[`DIRQC_PINSEL_A_EN]; // [R3]
  wire b_en = pinsel_r[`DIRQC_PINSEL_B_EN]; // [R3]
  wire a0 = a_en & (pina_code == 2'(dirqc_pkg::DIRQC_A_PIN0)); // [R4]
  wire a3 = a_en & (pina_code == 2'(dirqc_pkg::DIRQC_A_PIN3)); // [R4]
  wire a6 = a_en & (pina_code == 2'(dirqc_pkg::DIRQC_A_PIN6)); // [R4]
  wire b4 = b_en & ~pinsel_r[`DIRQC_PINSEL_B_SEL]; // [R5]
  wire b7 = b_en & pinsel_r[`DIRQC_PINSEL_B_SEL]; // [R5]
  wire [7:0] own_nxt = {b7, a6, 1'h0, b4, a3, 2'h0, a0};
  wire [7:0] pin_nxt = {b7 & lvl_b, a6 & lvl_a, 1'h0, b4 & lvl_b, a3 & lvl_a, 2'h0, a0 & lvl_a};

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_r <= 8'h00;
      own_r <= 8'h00;
    end else if (ce_i) begin
      pin_r <= pin_nxt; // [R7]
      own_r <= own_nxt;
    end
  end

  // ---------------------------------------------------------------
  // External detectors and wake-up
  // ---------------------------------------------------------------
  dirqc_ext_det u_ext_det (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .ext_pin_i(ext_pin_i),
    .cfg_i(extcfg_r),
    .det_o(ext_det)
  );

  wire [7:0] extsta_clr = (wr_commit & hit_extsta) ? wmask_data[7:0] : 8'h00;
  assign extsta_nxt = ext_det | (extsta_r & ~extsta_clr);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      extsta_r <= 8'h00;
      ext_irq_r <= 8'h00;
      wake_r <= 1'h0;
    end else if (ce_i) begin
      extsta_r <= extsta_nxt;
      ext_irq_r <= ext_det; // [R12]
      wake_r <= hibernate_i & (|ext_det); // [R15]
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign seq_b_accept_o = accept_r;
  assign ext_irq_o = ext_irq_r;
  assign wake_o = wake_r;
  assign port_pin_n_o = pin_r;
  assign port_pin_own_o = own_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  wire [31:0] set_a = evt_all & source_enable_reg_a_r & `DIRQC_FLAG_MASK;
  wire [31:0] clr_only_a = clr_vec & ~set_a;

  sequence s_req;
    ce_i && bus_req && wait_r;
  endsequence
  sequence s_ack;
    !avs_waitrequest_o;
  endsequence

  a_bus_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_req |=> s_ack)
    else $error("bus request not answered after one wait cycle");
  a_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R2]
    (ce_i && set_a != 32'h00000000) |=> ((source_flag_reg_a_r & $past(set_a)) == $past(set_a)))
    else $error("enabled event did not set group A flag");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R23]
    (clr_vec == 32'h00000000) |=> ((source_flag_reg_b_r & $past(source_flag_reg_b_r)) == $past(source_flag_reg_b_r)))
    else $error("group B flag dropped without clear");
  a_flag_unused: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R23]
    ((source_flag_reg_a_r | source_flag_reg_b_r) & ~`DIRQC_FLAG_MASK) == 32'h00000000)
    else $error("unassigned flag bit set");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R8]
    (ce_i && clr_only_a != 32'h00000000) |=> ((source_flag_reg_a_r & $past(clr_only_a)) == 32'h00000000))
    else $error("clear write left group A flag set");
  a_custom_guard: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R11]
    (!seq_wr_i && clr_vec[12:9] == 4'h0) |=> $stable(custom_event_reg_r))
    else $error("custom events changed without sequencer write");
  a_break_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R21]
    (ce_i && seq_b_req_i && seq_a_busy_i) |=> (!seq_b_accept_o && (source_flag_reg_a_r[31] ||
      !$past(source_enable_reg_a_r[31]))))
    else $error("refused sequence request not flagged");
  a_pin_level: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R7]
    (ce_i && a0) |=> (port_pin_n_o[0] == $past(lvl_a)))
    else $error("pin 0 does not follow group A level");
  a_wake_req: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R15]
    (ce_i && hibernate_i && ext_det != 8'h00) |=> wake_o)
    else $error("external event did not wake device");

endmodule : dirqc_top

`default_nettype wire

// >>> tb/dirqc_host_model.sv
// Host model that counts active interrupt edges on one pin
`timescale 1ns/100ps
`default_nettype none

module dirqc_host_model (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic pin_i, // Watched interrupt pin
  input wire logic pol_i, // Active edge, 1 rising
  output int edges_o // Active edges seen
);
  logic last_r;
  // Count only the edge that the polarity selects
  always @(posedge clk_i) begin
    if (rst_i) begin
      edges_o <= 0;
    end else if (pin_i !== last_r && pin_i === pol_i) begin
      edges_o <= edges_o + 1;
    end
    last_r <= pin_i;
  end
endmodule : dirqc_host_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the dual interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "dirqc_regs.svh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", nm, e, s); end end

module testbench;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, rd = 1'b0, wr = 1'b0, busy = 1'b0, breq = 1'b0;
  logic swr = 1'b0, hib = 1'b0, pol = 1'b1, ce = 1'b1, wreq, acc, wake;
  logic [15:0] adr = 16'h0000;
  logic [10:0] lvl = 11'h000;
  logic [31:0] wd = 32'h0, evt = 32'h0, q, rdata, en, c;
  logic [31:0] srcm = `DIRQC_FLAG_MASK & ~`DIRQC_LOCAL_MASK;
  logic [3:0] sdat = 4'h0;
  logic [7:0] ext = 8'h00, pin, irq, own;
  int errors = 0, checked = 0, cyc = 0, seed = 11293, edges, exp_e = 0, n0 = 0, n1 = 0, nw = 0;

  // Clock
  initial forever #4 clk_i = ~clk_i;

  dirqc_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .src_evt_i(evt), .fifo_level_i(lvl),
    .seq_a_busy_i(busy), .seq_b_req_i(breq), .seq_b_accept_o(acc), .seq_wr_i(swr),
    .seq_wdata_i(sdat), .ext_pin_i(ext), .hibernate_i(hib), .ext_irq_o(irq), .wake_o(wake),
    .port_pin_n_o(pin), .port_pin_own_o(own));
  dirqc_host_model host_u (.clk_i(clk_i), .rst_i(sys_rst_i), .pin_i(pin[0]), .pol_i(pol),
    .edges_o(edges));

  // Verdict and end of run
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
    wr <= w;
    rd <= ~w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  // One-cycle pulse on the source event inputs
  task automatic pulse(input logic [31:0] v);
    evt <= v;
    @(posedge clk_i);
    evt <= 32'h0;
    repeat (2) @(posedge clk_i);
  endtask : pulse

  // Cycle ceiling, detector line counters and wake counter
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  always @(negedge clk_i) begin
    n0 += irq[0];
    n1 += irq[1];
    nw += wake;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, `DIRQC_OFS_SEL_A, 0); `CHK("sel_a", 32'h00002000, q)
    bus(0, `DIRQC_OFS_POL, 0); `CHK("pol", 32'h00000000, q)
    bus(1, `DIRQC_OFS_POL, 1);
    bus(1, `DIRQC_OFS_PINSEL, 32'h00000034);
    bus(0, `DIRQC_OFS_PINSEL, 0); `CHK("own", 8'h81, own)
    `CHK("pinsel", 32'h00000034, q)
    $display("test reset_route done");
    repeat (4) begin
      en = $random(seed);
      c = $random(seed);
      bus(1, `DIRQC_OFS_CLR, 32'hFFFFFFFF);
      bus(1, `DIRQC_OFS_SEL_A, en);
      bus(1, `DIRQC_OFS_SEL_B, 32'hFFFFFFFF);
      pulse(32'hFFFFFFFF);
      exp_e += |(en & srcm);
      bus(0, `DIRQC_OFS_FLAG_A, 0); `CHK("flag_a", en & srcm, q)
      bus(0, `DIRQC_OFS_FLAG_B, 0); `CHK("flag_b", srcm, q)
      `CHK("pin_a", |(en & srcm), pin[0])
      `CHK("pin_b", 1'b1, pin[7])
      bus(1, `DIRQC_OFS_CLR, c);
      bus(0, `DIRQC_OFS_FLAG_A, 0); `CHK("clr", en & srcm & ~c, q)
    end
    `CHK("edges", exp_e, edges)
    $display("test sources done");
    bus(1, `DIRQC_OFS_CLR, 32'hFFFFFFFF);
    bus(1, `DIRQC_OFS_SEL_A, 1);
    bus(1, `DIRQC_OFS_POL, 0);
    pol <= 1'b0;
    @(posedge clk_i);
    `CHK("idle_hi", 1'b1, pin[0])
    pulse(1);
    `CHK("fall", 1'b0, pin[0])
    @(posedge clk_i);
    `CHK("edges_n", exp_e + 1, edges)
    $display("test polarity done");
    bus(1, `DIRQC_OFS_CLR, 32'hFFFFFFFF);
    bus(1, `DIRQC_OFS_SEL_A, 32'h80001E00);
    bus(1, `DIRQC_OFS_CUSTOM, 32'h0000000F);
    bus(0, `DIRQC_OFS_CUSTOM, 0); `CHK("cust_bus", 32'h0, q)
    swr <= 1'b1;
    sdat <= 4'h5;
    busy <= 1'b1;
    breq <= 1'b1;
    repeat (2) @(posedge clk_i);
    swr <= 1'b0;
    breq <= 1'b0;
    `CHK("accept", 1'b0, acc)
    bus(0, `DIRQC_OFS_FLAG_A, 0); `CHK("cust_flag", 32'h80000A00, q)
    bus(0, `DIRQC_OFS_CUSTOM, 0); `CHK("cust_seq", 32'h00000005, q)
    // Clock enable low: a sequencer write must not be taken
    ce <= 1'b0;
    swr <= 1'b1;
    sdat <= 4'h2;
    @(posedge clk_i);
    ce <= 1'b1;
    swr <= 1'b0;
    bus(0, `DIRQC_OFS_FLAG_A, 0); `CHK("ce_hold", 32'h80000A00, q)
    // FIFO level crossing the threshold setting raises flag 25
    bus(1, `DIRQC_OFS_CLR, 32'hFFFFFFFF);
    bus(1, `DIRQC_OFS_SEL_B, 32'h02000000);
    bus(1, `DIRQC_OFS_FIFOTHR, 32'h00000010);
    lvl <= 11'h010;
    @(posedge clk_i);
    bus(0, `DIRQC_OFS_FLAG_B, 0); `CHK("fifo_thr", 32'h02000000, q)
    $display("test custom_break done");
    bus(1, `DIRQC_OFS_EXTCFG, 32'h00000041);
    hib <= 1'b1;
    ext <= 8'h03;
    repeat (6) @(posedge clk_i);
    ext <= 8'h00;
    repeat (4) @(posedge clk_i);
    `CHK("rise", 1, n0)
    `CHK("level", 6, n1)
    `CHK("wake", 1'b1, nw > 0)
    $display("test external done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
